/* File: design/tpf_params.svh */
/*
 * tpf_params.svh - offsets, widths, reset values and counts of the triple-port queue controller.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef TPF_PARAMS_SVH
`define TPF_PARAMS_SVH

`define TPF_A_W 36
`define TPF_BC_W 18
`define TPF_DEPTH 256
`define TPF_PTR_W 8
`define TPF_OFS_W 8
`define TPF_SER_BITS 32
`define TPF_SER_CNT_W 6
`define TPF_OFS_DEF_LO 8'h08
`define TPF_OFS_DEF_MID 8'h10
`define TPF_OFS_DEF_HI 8'h40
`define TPF_BUF_DEPTH 2

`endif

/* File: design/tpf_pkg.sv */
/*
 * tpf_pkg.sv - types shared by the triple-port queue controller files.
 * Assumes tpf_params.svh is on the include path.
 */
`include "tpf_params.svh"

package tpf_pkg;
    // how the four flag offsets get their values
    typedef enum logic [1:0] {
        TPF_OFS_DEFAULT = 2'b00,
        TPF_OFS_PARALLEL = 2'b01,
        TPF_OFS_SERIAL = 2'b10
    } tpf_ofs_mode_t;
endpackage

/* File: design/tpf_skid_buf.sv */
/*
 * tpf_skid_buf.sv - two-entry buffer with valid/ready on both sides.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
`include "tpf_params.svh"

module tpf_skid_buf #(
    parameter int WIDTH = 18
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem_q [`TPF_BUF_DEPTH];
    logic rd_q;
    logic wr_q;
    logic [1:0] cnt_q;
    wire push = in_valid_in && (cnt_q != 2'h2);
    wire pop = out_ready_in && (cnt_q != 2'h0);

    // ready stays honest so the source really stalls when both slots hold words
    assign in_ready_out = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out = mem_q[rd_q];

    // pointer and count update
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage written by index, no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // a full buffer that nobody drains must keep both words untouched
    a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cnt_q == 2'h2 && !out_ready_in |=> cnt_q == 2'h2
        && $stable(mem_q[0]) && $stable(mem_q[1]))
        else $error("buffer overwritten while full");
endmodule

/* File: design/tpf_port_ctrl.sv */
/*
 * tpf_port_ctrl.sv - port qualification, flags, offset programming and mailboxes
 * of a triple-port queue device (port A 36-bit two-way, port B read, port C write).
 * Assumes all three ports share CLK_IN (one domain) and inputs synchronous to it;
 * the testbench resolves the tri-state buses from the enable outputs.
 */
// Functional notes
// - port A access only on edges where port A select is low.
// - port A data drivers released while port A select is high.
// - port B read only on edges where port B select is low.
// - port B data drivers released while port B select is high.
// - port A access only on edges where port A enable is high.
// - port A empty/out-ready reflects C-to-A queue by timing mode; here it follows C-to-A queue not-empty, also held high on a read edge in fall-through mode.
// - port B empty/out-ready reflects A-to-B queue by timing mode; here it follows the port B buffer in both modes.
// - port A full/in-ready reflects A-to-B queue space by mode; here it is A-to-B not-full and offsets loaded, in both modes.
// - port C full/in-ready reflects C-to-A queue space by mode; here it is C-to-A not-full in both modes.
// - at master reset offset pins pick default, parallel or serial.
// - serial load shifts a bit on each edge with serial enable low.
// - a full serial load takes 32 bits for this depth.
// - first serial bit is almost-full MSB, last is almost-empty LSB.
// - port A mailbox select steers access to mailboxes, reads mailbox two.
// - port B mailbox select presents mailbox one, else queue output.
// - port C write with mailbox select high goes to mailbox two.
// - port A direction high writes, low reads.
// - mailbox one refuses writes while its flag is low.
`timescale 1ns/100ps
`include "tpf_params.svh"

module tpf_port_ctrl
    import tpf_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PORT_A_SELECT_N_IN,
    input wire logic PORT_A_ACCESS_ENABLE_IN,
    input wire logic PORT_A_DIRECTION_SELECT_IN,
    input wire logic PORT_A_MAILBOX_SELECT_IN,
    input wire logic [`TPF_A_W-1:0] PORT_A_DATA_BUS_IN,
    output logic [`TPF_A_W-1:0] PORT_A_DATA_BUS_OUT,
    output logic PORT_A_DATA_BUS_OE_N_OUT,
    output logic PORT_A_EMPTY_OR_OUT_READY_OUT,
    output logic PORT_A_FULL_OR_IN_READY_OUT,
    input wire logic PORT_B_SELECT_N_IN,
    input wire logic PORT_B_READ_ENABLE_IN,
    input wire logic PORT_B_MAILBOX_SELECT_IN,
    output logic [`TPF_BC_W-1:0] PORT_B_DATA_BUS_OUT,
    output logic PORT_B_DATA_BUS_OE_N_OUT,
    output logic PORT_B_EMPTY_OR_OUT_READY_OUT,
    input wire logic PORT_C_WRITE_ENABLE_IN,
    input wire logic PORT_C_MAILBOX_SELECT_IN,
    input wire logic [`TPF_BC_W-1:0] PORT_C_DATA_IN,
    output logic PORT_C_FULL_OR_IN_READY_OUT,
    input wire logic ENDIAN_OR_TIMING_SELECT_IN,
    input wire logic SERIAL_PROG_SELECT_N_IN,
    input wire logic OFFSET_SELECT_HI_OR_SERIAL_ENABLE_N_IN,
    input wire logic OFFSET_SELECT_LO_OR_SERIAL_BIT_IN,
    output logic FIRST_MAILBOX_FLAG_N_OUT,
    output logic SECOND_MAILBOX_FLAG_N_OUT,
    output logic [`TPF_OFS_W-1:0] PORT_A_ALMOST_FULL_OFFSET_OUT,
    output logic [`TPF_OFS_W-1:0] PORT_C_ALMOST_FULL_OFFSET_OUT,
    output logic [`TPF_OFS_W-1:0] PORT_B_ALMOST_EMPTY_OFFSET_OUT,
    output logic [`TPF_OFS_W-1:0] PORT_A_ALMOST_EMPTY_OFFSET_OUT,
    output logic OFFSET_LOAD_DONE_OUT
);
    // ************************************************************
    // declarations
    // ************************************************************
    localparam int OW = `TPF_OFS_W;
    localparam int AW = `TPF_A_W;
    localparam int BW = `TPF_BC_W;
    localparam int PW = `TPF_PTR_W;

    logic [AW-1:0] ab_mem_q [`TPF_DEPTH];
    logic [AW-1:0] ca_mem_q [`TPF_DEPTH];
    logic [PW:0] ab_wr_q;
    logic [PW:0] ab_rd_q;
    logic [PW:0] ca_wr_q;
    logic [PW:0] ca_rd_q;
    logic [AW-1:0] mbox1_q;
    logic [BW-1:0] mbox2_q;
    logic mb1_flag_n_q;
    logic mb2_flag_n_q;
    tpf_ofs_mode_t ofs_mode_q;
    logic [4*OW-1:0] ofs_q;
    logic [`TPF_SER_CNT_W-1:0] ser_cnt_q;
    logic ofs_done_q;
    logic fall_thru_q;
    logic rst_seen_q;
    logic [AW-1:0] a_out_q;
    logic a_oe_n_q;
    logic a_ef_q;
    logic a_ff_q;
    logic b_ef_q;
    logic c_ff_q;

    // ************************************************************
    // qualification and decoding
    // ************************************************************
    // both select and enable must pass at the edge, else no port A word moves
    wire a_qual = !PORT_A_SELECT_N_IN && PORT_A_ACCESS_ENABLE_IN;
    wire a_wr = a_qual && PORT_A_DIRECTION_SELECT_IN;
    wire a_rd = a_qual && !PORT_A_DIRECTION_SELECT_IN;
    wire a_parallel = a_wr && ofs_mode_q == TPF_OFS_PARALLEL && !ofs_done_q;
    wire ab_full = (ab_wr_q[PW] != ab_rd_q[PW]) && (ab_wr_q[PW-1:0] == ab_rd_q[PW-1:0]);
    wire ab_empty = ab_wr_q == ab_rd_q;
    wire ca_full = (ca_wr_q[PW] != ca_rd_q[PW]) && (ca_wr_q[PW-1:0] == ca_rd_q[PW-1:0]);
    wire ca_empty = ca_wr_q == ca_rd_q;
    // port A writes to the A-to-B queue wait until offsets are in place; port C writes do not
    wire ab_push = a_wr && !PORT_A_MAILBOX_SELECT_IN && !ab_full && ofs_done_q;
    wire mb1_wr = a_wr && PORT_A_MAILBOX_SELECT_IN && mb1_flag_n_q;
    wire ca_pop = a_rd && !PORT_A_MAILBOX_SELECT_IN && !ca_empty;
    wire mb2_rd = a_rd && PORT_A_MAILBOX_SELECT_IN;
    wire c_wr = PORT_C_WRITE_ENABLE_IN;
    wire ca_push = c_wr && !PORT_C_MAILBOX_SELECT_IN && !ca_full;
    wire mb2_wr = c_wr && PORT_C_MAILBOX_SELECT_IN && mb2_flag_n_q;
    wire ser_shift = ofs_mode_q == TPF_OFS_SERIAL && !ofs_done_q
        && !OFFSET_SELECT_HI_OR_SERIAL_ENABLE_N_IN;
    // port B drains through the buffer so a receiver stall loses nothing
    wire b_sel = !PORT_B_SELECT_N_IN;
    wire b_take = b_sel && PORT_B_READ_ENABLE_IN;
    wire bq_in_ready;
    wire bq_valid;
    wire [BW-1:0] bq_data;
    wire ab_pop = !ab_empty && bq_in_ready;
    wire bq_pop = b_take && !PORT_B_MAILBOX_SELECT_IN && bq_valid;
    wire mb1_rd = b_take && PORT_B_MAILBOX_SELECT_IN;

    // preset offset picked from the two select pins at reset
    function automatic logic [OW-1:0] def_ofs(input logic hi, input logic lo);
        def_ofs = hi ? `TPF_OFS_DEF_HI : (lo ? `TPF_OFS_DEF_MID : `TPF_OFS_DEF_LO);
    endfunction

    // ************************************************************
    // port B buffer
    // ************************************************************
    // only the low half of each port A word travels to the narrow port
    tpf_skid_buf #(.WIDTH(BW)) u_bq (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .in_valid_in(!ab_empty),
        .in_ready_out(bq_in_ready),
        .in_data_in(ab_mem_q[ab_rd_q[PW-1:0]][BW-1:0]),
        .out_valid_out(bq_valid),
        .out_ready_in(bq_pop),
        .out_data_out(bq_data)
    );

    // ************************************************************
    // queues
    // ************************************************************
    // pointer update; the port A pointers never move on an unqualified edge, the A-to-B read pointer does
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ab_wr_q <= '0;
            ab_rd_q <= '0;
            ca_wr_q <= '0;
            ca_rd_q <= '0;
        end else begin
            ab_wr_q <= ab_wr_q + {{PW{1'b0}}, ab_push};
            ab_rd_q <= ab_rd_q + {{PW{1'b0}}, ab_pop};
            ca_wr_q <= ca_wr_q + {{PW{1'b0}}, ca_push};
            ca_rd_q <= ca_rd_q + {{PW{1'b0}}, ca_pop};
        end
    end

    // storage; port C words are zero-extended into the wide queue
    always_ff @(posedge CLK_IN) begin
        if (ab_push) begin
            ab_mem_q[ab_wr_q[PW-1:0]] <= PORT_A_DATA_BUS_IN;
        end
        if (ca_push) begin
            ca_mem_q[ca_wr_q[PW-1:0]] <= {{(AW-BW){1'b0}}, PORT_C_DATA_IN};
        end
    end

    // ************************************************************
    // mailboxes
    // ************************************************************
    // a write beats a read in the same cycle: write needs the flag high, read sets it
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            mbox1_q <= '0;
            mbox2_q <= '0;
            mb1_flag_n_q <= 1'b1;
            mb2_flag_n_q <= 1'b1;
        end else begin
            if (mb1_wr) begin
                mbox1_q <= PORT_A_DATA_BUS_IN;
            end
            if (mb2_wr) begin
                mbox2_q <= PORT_C_DATA_IN;
            end
            mb1_flag_n_q <= mb1_wr ? 1'b0 : (mb1_rd ? 1'b1 : mb1_flag_n_q);
            mb2_flag_n_q <= mb2_wr ? 1'b0 : (mb2_rd ? 1'b1 : mb2_flag_n_q);
        end
    end

    // ************************************************************
    // offset programming
    // ************************************************************
    // mode and presets caught by a clocked process on the first edge after reset release;
    // the straps seen on that edge win
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            rst_seen_q <= 1'b1;
            ofs_mode_q <= TPF_OFS_DEFAULT;
            ofs_done_q <= 1'b0;
            ser_cnt_q <= '0;
            ofs_q <= '0;
            fall_thru_q <= 1'b0;
        end else begin
            rst_seen_q <= 1'b0;
            if (rst_seen_q) begin
                // first cycle after release: latch method and timing mode
                fall_thru_q <= !ENDIAN_OR_TIMING_SELECT_IN;
                if (!SERIAL_PROG_SELECT_N_IN) begin
                    ofs_mode_q <= TPF_OFS_SERIAL;
                end else if (OFFSET_SELECT_HI_OR_SERIAL_ENABLE_N_IN
                        && OFFSET_SELECT_LO_OR_SERIAL_BIT_IN) begin
                    ofs_mode_q <= TPF_OFS_PARALLEL;
                end else begin
                    ofs_mode_q <= TPF_OFS_DEFAULT;
                    ofs_done_q <= 1'b1;
                    ofs_q <= {4{def_ofs(OFFSET_SELECT_HI_OR_SERIAL_ENABLE_N_IN,
                        OFFSET_SELECT_LO_OR_SERIAL_BIT_IN)}};
                end
            end else if (ser_shift) begin
                // msb-first shift: first bit ends at the top of the first offset
                ofs_q <= {ofs_q[4*OW-2:0], OFFSET_SELECT_LO_OR_SERIAL_BIT_IN};
                ser_cnt_q <= ser_cnt_q + 6'h01;
                ofs_done_q <= ser_cnt_q == 6'(`TPF_SER_BITS - 1);
            end else if (a_parallel) begin
                // one port A write carries all four offsets, first in the top byte
                ofs_q <= PORT_A_DATA_BUS_IN[4*OW-1:0];
                ofs_done_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // outputs and flags
    // ************************************************************
    // flags are registered so every pin comes straight from a flop;
    // polarity: high means not empty / not full in both timing modes
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            a_out_q <= '0;
            a_oe_n_q <= 1'b1;
            a_ef_q <= 1'b0;
            a_ff_q <= 1'b0;
            b_ef_q <= 1'b0;
            c_ff_q <= 1'b0;
        end else begin
            a_oe_n_q <= PORT_A_SELECT_N_IN || PORT_A_DIRECTION_SELECT_IN;
            if (mb2_rd) begin
                a_out_q <= {{(AW-BW){1'b0}}, mbox2_q};
            end else if (ca_pop) begin
                a_out_q <= ca_mem_q[ca_rd_q[PW-1:0]];
            end
            a_ef_q <= fall_thru_q ? (!ca_empty || ca_pop) : !ca_empty;
            a_ff_q <= ofs_done_q && !ab_full;
            b_ef_q <= bq_valid;
            c_ff_q <= !ca_full;
        end
    end

    // port B output register: mailbox or queue word, released when deselected
    logic [BW-1:0] b_out_q;
    logic b_oe_n_q;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            b_out_q <= '0;
            b_oe_n_q <= 1'b1;
        end else begin
            b_oe_n_q <= !b_sel;
            if (mb1_rd) begin
                b_out_q <= mbox1_q[BW-1:0];
            end else if (bq_pop) begin
                b_out_q <= bq_data;
            end
        end
    end

    assign PORT_A_DATA_BUS_OUT = a_out_q;
    assign PORT_A_DATA_BUS_OE_N_OUT = a_oe_n_q;
    assign PORT_A_EMPTY_OR_OUT_READY_OUT = a_ef_q;
    assign PORT_A_FULL_OR_IN_READY_OUT = a_ff_q;
    assign PORT_B_DATA_BUS_OUT = b_out_q;
    assign PORT_B_DATA_BUS_OE_N_OUT = b_oe_n_q;
    assign PORT_B_EMPTY_OR_OUT_READY_OUT = b_ef_q;
    assign PORT_C_FULL_OR_IN_READY_OUT = c_ff_q;
    assign FIRST_MAILBOX_FLAG_N_OUT = mb1_flag_n_q;
    assign SECOND_MAILBOX_FLAG_N_OUT = mb2_flag_n_q;
    assign PORT_A_ALMOST_FULL_OFFSET_OUT = ofs_q[4*OW-1:3*OW];
    assign PORT_C_ALMOST_FULL_OFFSET_OUT = ofs_q[3*OW-1:2*OW];
    assign PORT_B_ALMOST_EMPTY_OFFSET_OUT = ofs_q[2*OW-1:OW];
    assign PORT_A_ALMOST_EMPTY_OFFSET_OUT = ofs_q[OW-1:0];
    assign OFFSET_LOAD_DONE_OUT = ofs_done_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_a_desel;
        PORT_A_SELECT_N_IN;
    endsequence
    a_a_release: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_a_desel |=> PORT_A_DATA_BUS_OE_N_OUT)
        else $error("port A drives while deselected");
    a_b_release: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        PORT_B_SELECT_N_IN |=> PORT_B_DATA_BUS_OE_N_OUT)
        else $error("port B drives while deselected");
    a_a_unqual: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (PORT_A_SELECT_N_IN || !PORT_A_ACCESS_ENABLE_IN) && !PORT_C_WRITE_ENABLE_IN
        && bq_in_ready |=> $stable(ca_rd_q) && $stable(ab_wr_q) && $stable(mbox1_q))
        else $error("port A moved on unqualified edge");
    a_mb1_block: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !mb1_flag_n_q && !mb1_rd |=> $stable(mbox1_q) && !mb1_flag_n_q)
        else $error("mailbox one overwritten");
    a_mb2_route: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mb2_wr |=> mbox2_q == $past(PORT_C_DATA_IN) && !mb2_flag_n_q && $stable(ca_wr_q))
        else $error("port C mailbox write misrouted");
    a_ser_count: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ser_shift && ser_cnt_q == 6'h1F |=> ofs_done_q)
        else $error("serial load length wrong");
    a_ser_first: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ser_shift |=> ofs_q[0] == $past(OFFSET_SELECT_LO_OR_SERIAL_BIT_IN))
        else $error("serial bit order wrong");
    a_c_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ca_full |=> !PORT_C_FULL_OR_IN_READY_OUT)
        else $error("port C ready while full");
    a_a_full: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ab_full |=> !PORT_A_FULL_OR_IN_READY_OUT)
        else $error("port A ready while full");
    a_b_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !bq_valid |=> !PORT_B_EMPTY_OR_OUT_READY_OUT)
        else $error("port B ready with nothing buffered");
endmodule

/* File: sim/tpf_bus_model.sv */
/*
 * tpf_bus_model.sv - far side of ports A and B: the bus masters and the shared data wires.
 * Assumes the device enables are active low and change just after CLK_IN edges.
 */
`timescale 1ns/100ps

module tpf_bus_model (
    input wire logic clk_in,
    input wire logic [35:0] dev_a_in,
    input wire logic dev_a_oe_n_in,
    input wire logic [35:0] host_a_in,
    input wire logic host_a_drive_in,
    input wire logic [17:0] dev_b_in,
    input wire logic dev_b_oe_n_in,
    output logic [35:0] a_wire_out,
    output logic [17:0] b_wire_out
);
    // ****************************************
    // wire resolution
    // ****************************************
    logic [35:0] last_a_q = '0;
    logic [17:0] last_b_q = '0;
    // a released line flips each cycle so stale data never passes for a real word
    always_ff @(posedge clk_in) begin
        last_a_q <= a_wire_out;
        last_b_q <= b_wire_out;
    end
    // the master drives A only while it selects a write; contention shows as unknown
    assign a_wire_out = (!dev_a_oe_n_in && host_a_drive_in) ? 'x : !dev_a_oe_n_in ? dev_a_in :
        host_a_drive_in ? host_a_in : ~last_a_q;
    assign b_wire_out = !dev_b_oe_n_in ? dev_b_in : ~last_b_q;
endmodule

/* File: sim/tpf_port_ctrl_tb_top.sv */
/*
 * tpf_port_ctrl_tb_top.sv - self-checking bench of the triple-port queue controller.
 * Assumes one 100 MHz clock for all ports and the bus model for the data wires.
 */
`timescale 1ns/100ps

module tpf_port_ctrl_tb_top;
    logic clk_in, rst_n, a_sel_n, a_en, a_dir, a_mb, b_sel_n, b_ren, b_mb, c_we, c_mb;
    logic tsel, prog_n, hi, lo, a_oe_n, a_ef, a_ff, b_oe_n, b_ef, c_ff, mf1, mf2, done;
    logic [35:0] a_host, a_dout, a_wire;
    logic [17:0] c_d, b_dout, b_wire;
    logic [7:0] af_a, af_c, ae_b, ae_a;
    int error_cnt = 0;
    int total_checks = 0;

    // free-running clock, 10 ns period
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    tpf_port_ctrl tpf_port_ctrl_i (.CLK_IN(clk_in), .RST_N_IN(rst_n),
        .PORT_A_SELECT_N_IN(a_sel_n), .PORT_A_ACCESS_ENABLE_IN(a_en),
        .PORT_A_DIRECTION_SELECT_IN(a_dir), .PORT_A_MAILBOX_SELECT_IN(a_mb),
        .PORT_A_DATA_BUS_IN(a_wire), .PORT_A_DATA_BUS_OUT(a_dout),
        .PORT_A_DATA_BUS_OE_N_OUT(a_oe_n), .PORT_A_EMPTY_OR_OUT_READY_OUT(a_ef),
        .PORT_A_FULL_OR_IN_READY_OUT(a_ff), .PORT_B_SELECT_N_IN(b_sel_n),
        .PORT_B_READ_ENABLE_IN(b_ren), .PORT_B_MAILBOX_SELECT_IN(b_mb),
        .PORT_B_DATA_BUS_OUT(b_dout), .PORT_B_DATA_BUS_OE_N_OUT(b_oe_n),
        .PORT_B_EMPTY_OR_OUT_READY_OUT(b_ef), .PORT_C_WRITE_ENABLE_IN(c_we),
        .PORT_C_MAILBOX_SELECT_IN(c_mb), .PORT_C_DATA_IN(c_d), .PORT_C_FULL_OR_IN_READY_OUT(c_ff),
        .ENDIAN_OR_TIMING_SELECT_IN(tsel), .SERIAL_PROG_SELECT_N_IN(prog_n),
        .OFFSET_SELECT_HI_OR_SERIAL_ENABLE_N_IN(hi), .OFFSET_SELECT_LO_OR_SERIAL_BIT_IN(lo),
        .FIRST_MAILBOX_FLAG_N_OUT(mf1), .SECOND_MAILBOX_FLAG_N_OUT(mf2),
        .PORT_A_ALMOST_FULL_OFFSET_OUT(af_a), .PORT_C_ALMOST_FULL_OFFSET_OUT(af_c),
        .PORT_B_ALMOST_EMPTY_OFFSET_OUT(ae_b), .PORT_A_ALMOST_EMPTY_OFFSET_OUT(ae_a),
        .OFFSET_LOAD_DONE_OUT(done));

    tpf_bus_model tpf_bus_model_i (.clk_in(clk_in), .dev_a_in(a_dout), .dev_a_oe_n_in(a_oe_n),
        .host_a_in(a_host), .host_a_drive_in(a_dir), .dev_b_in(b_dout), .dev_b_oe_n_in(b_oe_n),
        .a_wire_out(a_wire), .b_wire_out(b_wire));

    // ****************************************
    // port tasks
    // ****************************************
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // every input moves 1 ns after the edge so the design samples settled values
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic a_idle();
        a_sel_n = 1'b1;
        a_en = 1'b0;
        a_dir = 1'b0;
        a_mb = 1'b0;
    endtask

    task automatic b_idle();
        b_sel_n = 1'b1;
        b_ren = 1'b0;
        b_mb = 1'b0;
    endtask

    // leaves the request standing so back-to-back calls never re-assign in one step
    task automatic a_acc(input logic s, e, d, m, input logic [35:0] w);
        a_sel_n = s;
        a_en = e;
        a_dir = d;
        a_mb = m;
        a_host = w;
        cyc();
    endtask

    task automatic b_rd(input logic m);
        b_sel_n = 1'b0;
        b_ren = 1'b1;
        b_mb = m;
        cyc();
    endtask

    task automatic c_wr(input logic m, input logic [17:0] w);
        c_we = 1'b1;
        c_mb = m;
        c_d = w;
        cyc();
    endtask

    // straps stay steady through the first edge after release
    task automatic rst(input logic s, h, l);
        rst_n = 1'b0;
        prog_n = s;
        hi = h;
        lo = l;
        c_mb = 1'b1;
        c_we = 1'b0;
        a_idle();
        b_idle();
        cyc(20);
        rst_n = 1'b1;
        cyc(2);
        hi = 1'b1;
        lo = 1'b0;
        c_mb = 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_presets();
        logic [7:0] exp [3] = '{8'h08, 8'h10, 8'h40};
        for (int k = 0; k < 3; k++) begin
            rst(1'b1, k[1], k[0]);
            chk("preset", {af_a, af_c, ae_b, ae_a}, {4{exp[k]}});
            chk("idle outs", {a_oe_n, b_oe_n, mf1, mf2, a_ef, b_ef, done}, 7'h79);
        end
    endtask

    task automatic t_parallel();
        rst(1'b1, 1'b1, 1'b1);
        a_acc(1'b0, 1'b0, 1'b1, 1'b0, 36'h0_5566_7788);
        a_acc(1'b1, 1'b1, 1'b1, 1'b0, 36'h0_5566_7788);
        a_idle();
        cyc();
        chk("unqualified", {af_a, af_c, ae_b, ae_a, a_ff}, 33'h0);
        a_acc(1'b0, 1'b1, 1'b1, 1'b0, 36'h0_1122_3344);
        a_idle();
        cyc();
        chk("parallel", {af_a, af_c, ae_b, ae_a}, 32'h1122_3344);
    endtask

    task automatic t_serial();
        logic [31:0] pat = 32'hA1B2C3D4;
        rst(1'b0, 1'b1, 1'b0);
        for (int i = 31; i >= 0; i--) begin
            if (i == 15) begin
                hi = 1'b1;
                lo = ~pat[i];
                cyc();
            end
            hi = 1'b0;
            lo = pat[i];
            cyc();
            if (i == 1) chk("done at 31", done, 1'b0);
        end
        hi = 1'b1;
        cyc();
        chk("serial done", done, 1'b1);
        chk("serial", {af_a, af_c, ae_b, ae_a}, pat);
    endtask

    task automatic t_queue();
        int n = 0;
        int k = 0;
        a_acc(1'b1, 1'b1, 1'b1, 1'b0, 36'hF_FFFF_FFFF);
        a_idle();
        cyc(4);
        chk("ignored write", b_ef, 1'b0);
        while (a_ff === 1'b1 && n < 300) begin
            a_acc(1'b0, 1'b1, 1'b1, 1'b0, {18'h2AAAA, 18'(n)});
            n++;
        end
        a_idle();
        // 256 queued plus 2 buffered are taken; the registered flag lets one refused write by
        chk("fill count", n, 36'd259);
        repeat (n) begin
            for (int t = 0; t < 10 && b_ef !== 1'b1; t++) cyc();
            if (b_ef !== 1'b1) break;
            b_rd(1'b0);
            chk("b word", b_wire, 18'(k));
            k++;
            b_idle();
            // the receiver stalls now and then; the buffer must hold its words
            cyc((k % 32 == 0) ? 6 : 1);
        end
        chk("drained", {k == 258, b_ef, a_ff, b_oe_n}, 4'hB);
    endtask

    task automatic t_mailbox();
        int n = 0;
        a_acc(1'b0, 1'b1, 1'b1, 1'b1, 36'h0_0001_2345);
        a_acc(1'b0, 1'b1, 1'b1, 1'b1, 36'h0_0000_0BAD);
        a_idle();
        cyc(4);
        chk("mbox1 full", {mf1, b_ef}, 2'b00);
        b_rd(1'b1);
        chk("mbox1 data", b_wire, 18'h12345);
        b_idle();
        cyc();
        c_wr(1'b1, 18'h2BEEF);
        c_we = 1'b0;
        cyc();
        chk("mbox2 full", {mf1, mf2, a_ef}, 3'b100);
        a_acc(1'b0, 1'b1, 1'b0, 1'b1, 36'h0);
        chk("mbox2 data", {a_oe_n, a_wire[17:0]}, 19'h2BEEF);
        a_idle();
        cyc();
        chk("mbox2 read", {mf2, a_oe_n}, 2'b11);
        c_wr(1'b0, 18'h01357);
        c_we = 1'b0;
        for (int t = 0; t < 10 && a_ef !== 1'b1; t++) cyc();
        chk("c to a", {a_ef, c_ff}, 2'b11);
        a_acc(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
        chk("a queue", a_wire, 36'h0_0001_357);
        a_idle();
        cyc(2);
        chk("a empty", a_ef, 1'b0);
        while (c_ff === 1'b1 && n < 300) begin
            c_wr(1'b0, 18'(n));
            n++;
        end
        c_we = 1'b0;
        // 256 words fit; the one-cycle flag lag lets one refused write by
        chk("c fill", n, 36'd257);
    endtask

    // fall-through timing: ready rises with a queued word and drops after it is read
    task automatic t_fall_thru();
        tsel = 1'b0;
        rst(1'b1, 1'b0, 1'b0);
        c_wr(1'b0, 18'h00ABC);
        c_we = 1'b0;
        cyc(2);
        chk("fall-through ready", {a_ef, c_ff, done}, 3'b111);
        a_acc(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
        chk("fall-through data", a_wire, 36'h0_0000_0ABC);
        a_idle();
        cyc(2);
        chk("fall-through empty", {a_ef, a_oe_n}, 2'b01);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        tsel = 1'b1;
        a_host = '0;
        c_d = '0;
        t_presets();
        t_parallel();
        t_serial();
        rst(1'b1, 1'b0, 1'b0);
        t_queue();
        t_mailbox();
        t_fall_thru();
        end_of_test();
    end
endmodule
